//--- mod_pt_params.svh
// Constants of the pass-thru command interpreter: codes, limits, offsets
// Assumes inclusion by bare name; holds definitions only
`ifndef MOD_PT_PARAMS_SVH
`define MOD_PT_PARAMS_SVH

// --------------------------------------------------------------------
// Control block identifiers
// --------------------------------------------------------------------
`define WARM_BOOT_ID   16'h270e
`define COLD_BOOT_ID   16'h270f

// --------------------------------------------------------------------
// Port role codes
// --------------------------------------------------------------------
`define ROLE_MASTER    3'h0
`define ROLE_SLAVE     3'h1
`define ROLE_BLOCK_PT  3'h2
`define ROLE_DIRECT    3'h4
`define ROLE_DIRECT_SW 3'h5

// --------------------------------------------------------------------
// Write function codes and count limits
// --------------------------------------------------------------------
`define FC_WR_COIL     8'h05
`define FC_WR_REG      8'h06
`define FC_WR_COILS    8'h0f
`define FC_WR_REGS     8'h10
`define MAX_REGS       16'h007d
`define MAX_COILS      16'h0320

// --------------------------------------------------------------------
// Exception codes, zero meaning a normal reply
// --------------------------------------------------------------------
`define EXC_NONE       8'h00
`define EXC_ILL_FUNC   8'h01
`define EXC_ILL_ADDR   8'h02
`define EXC_ILL_VALUE  8'h03
`define EXC_BUSY       8'h06

// --------------------------------------------------------------------
// Holding register area and block identifiers
// --------------------------------------------------------------------
`define HOLD_BASE      20'h09c41
`define HOLD_WORDS_DEF 16'h2710
`define BLK_ID_DIRECT  16'h0000
`define BLK_ID_COIL    16'h0f05
`define BLK_ID_REG     16'h0f06
`define BLK_ID_COILS   16'h0f0f
`define BLK_ID_REGS    16'h0f10

`endif

//--- mod_pt_pkg.sv
// Types shared by the pass-thru interpreter modules
// Assumes nothing of its surroundings
package mod_pt_pkg;

  // Per-port request handler states
  typedef enum logic [4:0] {
    ST_IDLE  = 5'h01,
    ST_CHECK = 5'h02,
    ST_DATA  = 5'h04,
    ST_DROP  = 5'h08,
    ST_REPLY = 5'h10
  } port_state_e;

  // One word bound for processor memory
  typedef struct packed {
    logic        first;
    logic [15:0] blk_id;
    logic [19:0] addr;
    logic [15:0] data;
  } bp_entry_s;

endpackage

//--- bp_if.sv
// Push side of the backplane transfer queue
// Assumes one producer and the queue on the same clock
`timescale 1ns/1ns
interface bp_if #(parameter int FREE_W = 6);
  logic                  push_valid;
  mod_pt_pkg::bp_entry_s push_entry;
  logic                  flush;
  logic [FREE_W-1:0]     free;

  modport prod (output push_valid, output push_entry, output flush, input free);
  modport fifo (input push_valid, input push_entry, input flush, output free);
endinterface

//--- ctrl_block.sv
// Control block decoder: warm and cold boot requests, sequence echo
// Assumes block words come from logic on the same clock
`timescale 1ns/1ns
`include "mod_pt_params.svh"
module ctrl_block (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        resetn,
  // Block request
  input  wire logic [15:0] blk_seq,
  input  wire logic [15:0] blk_id,
  // Block response and boot pulses
  output logic      [15:0] rsp_seq_r,
  output logic      [15:0] rsp_id_r,
  output logic             warm_r,
  output logic             cold_r
);
  logic [15:0] seen_r;
  logic        fresh;

  // A block counts only once its sequence number moves
  assign fresh = (blk_seq != seen_r);

  // Last sequence number handled
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      seen_r <= 16'h0000;
    else if (fresh)
      seen_r <= blk_seq;
  end

  // Response carries the request sequence plus one
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rsp_seq_r <= 16'h0000;
      rsp_id_r  <= 16'h0000;
    end
    else if (fresh)
    begin
      rsp_seq_r <= blk_seq + 16'h0001;
      rsp_id_r  <= blk_id;
    end
  end

  // Boot pulses; spare words are never looked at
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      warm_r <= 1'b0;
      cold_r <= 1'b0;
    end
    else
    begin
      warm_r <= fresh && (blk_id == `WARM_BOOT_ID);
      cold_r <= fresh && (blk_id == `COLD_BOOT_ID);
    end
  end
endmodule

//--- bp_queue.sv
// Backplane transfer queue with a registered output stage
// Assumes producers reserve room through the free count before pushing
`timescale 1ns/1ns
module bp_queue #(
  parameter int DEPTH = 32
)(
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             resetn,
  // Push side
  bp_if.fifo                    in_q,
  // Drain side towards processor memory
  output logic                  out_valid_r,
  output mod_pt_pkg::bp_entry_s out_entry_r,
  input  wire logic             out_ready
);
  localparam int AW = $clog2(DEPTH);
  localparam int FW = $clog2(DEPTH + 1);

  // Pointers wrap freely only for a power of two depth
  if ((DEPTH < 2) || ((1 << AW) != DEPTH) || ($bits(in_q.free) != FW))
  begin : g_bad_depth
    $error("bp_queue: depth must be a power of two matching the free width");
  end

  mod_pt_pkg::bp_entry_s mem [DEPTH];
  logic [AW-1:0]         wptr_r;
  logic [AW-1:0]         rptr_r;
  logic [FW-1:0]         cnt_r;
  logic                  push;
  logic                  pop;

  assign push = in_q.push_valid && (cnt_r != FW'(DEPTH));
  assign pop  = (cnt_r != '0) && (!out_valid_r || out_ready);
  assign in_q.free = FW'(DEPTH) - cnt_r;

  // Storage; no reset needed on the data itself
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wptr_r] <= in_q.push_entry;
  end

  // Pointers and fill level
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end
    else if (in_q.flush)
    begin
      wptr_r <= '0;
      rptr_r <= '0;
      cnt_r  <= '0;
    end
    else
    begin
      wptr_r <= wptr_r + AW'(push);
      rptr_r <= rptr_r + AW'(pop);
      cnt_r  <= cnt_r + FW'(push) - FW'(pop);
    end
  end

  // Output stage stalls while the processor side is not ready
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      out_valid_r <= 1'b0;
      out_entry_r <= '0;
    end
    else if (in_q.flush)
      out_valid_r <= 1'b0;
    else if (pop)
    begin
      out_valid_r <= 1'b1;
      out_entry_r <= mem[rptr_r];
    end
    else if (out_ready)
      out_valid_r <= 1'b0;
  end
endmodule

//--- modbus_slave_pass_thru.sv
// Top of the pass-thru command interpreter: control blocks and two ports
// Assumes framed Modbus requests arrive on this clock; cts comes from pins
`timescale 1ns/1ns
`include "mod_pt_params.svh"
module modbus_slave_pass_thru #(
  parameter int          QUEUE_DEPTH = 32,
  parameter logic [15:0] HOLD_WORDS  = `HOLD_WORDS_DEF
)(
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              resetn,
  // Control block from the processor
  input  wire logic [15:0]       blk_seq,
  input  wire logic [15:0]       blk_id,
  output logic      [15:0]       blk_rsp_seq,
  output logic      [15:0]       blk_rsp_id,
  output logic                   warm_boot,
  output logic                   cold_boot,
  // Port configuration
  input  wire logic [1:0][2:0]   role,
  input  wire logic [1:0]        clear_to_send_handshake_on,
  // Framed requests from each port
  input  wire logic [1:0]        req_valid,
  input  wire logic [1:0][7:0]   req_func,
  input  wire logic [1:0][15:0]  req_addr,
  input  wire logic [1:0][15:0]  req_count,
  output logic      [1:0]        req_ready,
  // Request data words
  input  wire logic [1:0]        wr_valid,
  input  wire logic [1:0][15:0]  wr_data,
  input  wire logic [1:0]        wr_last,
  output logic      [1:0]        wr_ready,
  // Replies and modem lines
  output logic      [1:0]        rsp_valid,
  output logic      [1:0][7:0]   rsp_exc,
  output logic      [1:0]        rts,
  input  wire logic [1:0]        cts,
  // Towards processor holding memory
  output logic                   bp_valid,
  output logic                   bp_first,
  output logic      [15:0]       bp_blk_id,
  output logic      [19:0]       bp_addr,
  output logic      [15:0]       bp_data,
  input  wire logic              bp_ready
);
  localparam int FW = $clog2(QUEUE_DEPTH + 1);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  if (QUEUE_DEPTH < 2)
  begin : g_bad_depth
    $error("modbus_slave_pass_thru: queue depth too small");
  end

  // --------------------------------------------------------------------
  // Decoding helpers
  // --------------------------------------------------------------------
  // Pass-thru roles are handled here; master and slave roles are not
  function automatic logic is_pt(input logic [2:0] r);
    is_pt = (r == `ROLE_DIRECT) || (r == `ROLE_DIRECT_SW) || (r == `ROLE_BLOCK_PT);
  endfunction

  // Words a request carries; coils pack sixteen to a word
  function automatic logic [15:0] words_of(input logic [7:0] fc, input logic [15:0] cnt);
    logic [16:0] bits;
    bits = {1'b0, cnt} + 17'h0000f;
    if (fc == `FC_WR_REGS)
      words_of = cnt;
    else if (fc == `FC_WR_COILS)
      words_of = {3'h0, bits[16:4]};
    else
      words_of = 16'h0001;
  endfunction

  // Exception for a request, or none
  function automatic logic [7:0] check_req(input logic [2:0]  r,
                                           input logic [7:0]  fc,
                                           input logic [15:0] addr,
                                           input logic [15:0] cnt,
                                           input logic [15:0] limit);
    logic [16:0] end_a;
    logic        fc_ok;
    logic        cnt_ok;
    end_a  = {1'b0, addr} + {1'b0, words_of(fc, cnt)};
    fc_ok  = (fc == `FC_WR_REG) || (fc == `FC_WR_REGS);
    if (r == `ROLE_BLOCK_PT)
      fc_ok = fc_ok || (fc == `FC_WR_COIL) || (fc == `FC_WR_COILS);
    cnt_ok = 1'b1;
    if (fc == `FC_WR_REGS)
      cnt_ok = (cnt != 16'h0000) && (cnt <= `MAX_REGS);
    else if (fc == `FC_WR_COILS)
      cnt_ok = (cnt != 16'h0000) && (cnt <= `MAX_COILS);
    if (!fc_ok)
      check_req = `EXC_ILL_FUNC;
    else if (!cnt_ok)
      check_req = `EXC_ILL_VALUE;
    else if (end_a > {1'b0, limit})
      check_req = `EXC_ILL_ADDR;
    else
      check_req = `EXC_NONE;
  endfunction

  // Block ID follows the write function type in the block role; other roles get BLK_ID_DIRECT
  function automatic logic [15:0] blk_id_of(input logic [2:0] r, input logic [7:0] fc);
    if (r != `ROLE_BLOCK_PT)
      blk_id_of = `BLK_ID_DIRECT;
    else if (fc == `FC_WR_COIL)
      blk_id_of = `BLK_ID_COIL;
    else if (fc == `FC_WR_REG)
      blk_id_of = `BLK_ID_REG;
    else if (fc == `FC_WR_COILS)
      blk_id_of = `BLK_ID_COILS;
    else
      blk_id_of = `BLK_ID_REGS;
  endfunction

  // --------------------------------------------------------------------
  // Control blocks and the boot flush
  // --------------------------------------------------------------------
  logic flush;

  ctrl_block u_ctrl (
    .clk       (clk),
    .resetn    (resetn),
    .blk_seq   (blk_seq),
    .blk_id    (blk_id),
    .rsp_seq_r (blk_rsp_seq),
    .rsp_id_r  (blk_rsp_id),
    .warm_r    (warm_boot),
    .cold_r    (cold_boot)
  );

  // Either boot clears ports and queue; a cold boot also asks for reset
  assign flush = warm_boot || cold_boot;

  // --------------------------------------------------------------------
  // Clear-to-send synchronisers
  // --------------------------------------------------------------------
  logic [1:0] cts_m_r;
  logic [1:0] cts_s_r;

  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      cts_m_r <= 2'h0;
      cts_s_r <= 2'h0;
    end
    else
    begin
      cts_m_r <= cts;
      cts_s_r <= cts_m_r;
    end
  end

  // --------------------------------------------------------------------
  // Queue and its single-owner lock
  // --------------------------------------------------------------------
  bp_if #(.FREE_W(FW)) bp ();

  wire [1:0]             want;
  wire [1:0]             take;
  wire [1:0]             rel;
  wire [1:0]             push_req;
  wire [1:0]             grant;
  mod_pt_pkg::bp_entry_s ent [2];
  mod_pt_pkg::bp_entry_s q_out;
  logic [1:0]            lock_r;

  // Port 0 wins a tie; the loser simply waits in its check state
  assign grant[0] = want[0] && (lock_r == 2'h0);
  assign grant[1] = want[1] && !want[0] && (lock_r == 2'h0);

  // Lock keeps one port's words contiguous in the queue
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      lock_r <= 2'h0;
    else if (flush)
      lock_r <= 2'h0;
    else
      lock_r <= (lock_r | take) & ~rel;
  end

  // Only the lock owner can be pushing
  assign bp.push_valid = |push_req;
  assign bp.push_entry = lock_r[1] ? ent[1] : ent[0];
  assign bp.flush      = flush;

  bp_queue #(.DEPTH(QUEUE_DEPTH)) u_queue (
    .clk         (clk),
    .resetn      (resetn),
    .in_q        (bp.fifo),
    .out_valid_r (bp_valid),
    .out_entry_r (q_out),
    .out_ready   (bp_ready)
  );

  // Written straight into processor memory, no program needed there
  assign bp_first  = q_out.first;
  assign bp_blk_id = q_out.blk_id;
  assign bp_addr   = q_out.addr;
  assign bp_data   = q_out.data;

  // --------------------------------------------------------------------
  // Per-port request handlers, sharing the queue and its lock
  // --------------------------------------------------------------------
  genvar p;
  for (p = 0; p < 2; p++)
  begin : g_port
    mod_pt_pkg::port_state_e st_r;
    mod_pt_pkg::port_state_e st_nxt;
    logic [7:0]  fc_r;
    logic [15:0] addr_r;
    logic [15:0] cnt_r;
    logic [7:0]  exc_r;
    logic [19:0] tgt_r;
    logic        first_r;
    logic        rdy_r;
    logic        wrdy_r;
    logic        rts_r;
    logic        rsp_r;
    logic [7:0]  rexc_r;
    logic [7:0]  chk;
    logic        fits;
    logic [15:0] word;

    assign chk  = check_req(role[p], fc_r, addr_r, cnt_r, HOLD_WORDS);
    assign fits = 16'(bp.free) >= words_of(fc_r, cnt_r);
    assign want[p] = (st_r == mod_pt_pkg::ST_CHECK) && (chk == `EXC_NONE);
    assign take[p] = (st_r == mod_pt_pkg::ST_CHECK) && (st_nxt == mod_pt_pkg::ST_DATA);
    assign rel[p]  = (st_r == mod_pt_pkg::ST_DATA) && (st_nxt != mod_pt_pkg::ST_DATA);

    // Byte order swap for the swapping role
    assign word = (role[p] == `ROLE_DIRECT_SW) ? {wr_data[p][7:0], wr_data[p][15:8]}
                                                : wr_data[p];

    // Words go only to the queue; there is no database write path
    assign push_req[p] = (st_r == mod_pt_pkg::ST_DATA) && wr_valid[p];
    assign ent[p] = '{first_r, blk_id_of(role[p], fc_r), tgt_r, word};

    // Next state
    always_comb
    begin
      st_nxt = st_r;
      unique case (st_r)
        mod_pt_pkg::ST_IDLE:
          if (req_valid[p] && rdy_r)
            st_nxt = mod_pt_pkg::ST_CHECK;
        mod_pt_pkg::ST_CHECK:
          if (chk != `EXC_NONE)
            st_nxt = mod_pt_pkg::ST_DROP;
          else if (grant[p])
            st_nxt = fits ? mod_pt_pkg::ST_DATA : mod_pt_pkg::ST_DROP;
        mod_pt_pkg::ST_DATA:
          if (wr_valid[p] && wr_last[p])
            st_nxt = mod_pt_pkg::ST_REPLY;
        mod_pt_pkg::ST_DROP:
          if (wr_valid[p] && wr_last[p])
            st_nxt = mod_pt_pkg::ST_REPLY;
        mod_pt_pkg::ST_REPLY:
          if (!clear_to_send_handshake_on[p] || cts_s_r[p])
            st_nxt = mod_pt_pkg::ST_IDLE;
      endcase
      if (flush)
        st_nxt = mod_pt_pkg::ST_IDLE;
    end

    // State
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        st_r <= mod_pt_pkg::ST_IDLE;
      else
        st_r <= st_nxt;
    end

    // Request header, caught as the request is taken
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        fc_r   <= 8'h00;
        addr_r <= 16'h0000;
        cnt_r  <= 16'h0000;
      end
      else if ((st_r == mod_pt_pkg::ST_IDLE) && (st_nxt == mod_pt_pkg::ST_CHECK))
      begin
        fc_r   <= req_func[p];
        addr_r <= req_addr[p];
        cnt_r  <= req_count[p];
      end
    end

    // Exception held for the reply
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
        exc_r <= `EXC_NONE;
      else if (st_r == mod_pt_pkg::ST_CHECK)
      begin
        if (chk != `EXC_NONE)
          exc_r <= chk;
        else if (grant[p] && !fits)
          exc_r <= `EXC_BUSY;
        else
          exc_r <= `EXC_NONE;
      end
    end

    // Target address; block roles pass the raw destination to the processor
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        tgt_r   <= 20'h00000;
        first_r <= 1'b0;
      end
      else if (take[p])
      begin
        tgt_r   <= (role[p] == `ROLE_BLOCK_PT) ? {4'h0, addr_r}
                                               : `HOLD_BASE + {4'h0, addr_r};
        first_r <= 1'b1;
      end
      else if (push_req[p])
      begin
        tgt_r   <= tgt_r + 20'h00001;
        first_r <= 1'b0;
      end
    end

    // Port outputs, all registered; ready and rts from the next state, reply on leaving REPLY
    always_ff @(posedge clk or negedge resetn)
    begin
      if (!resetn)
      begin
        rdy_r  <= 1'b0;
        wrdy_r <= 1'b0;
        rts_r  <= 1'b0;
        rsp_r  <= 1'b0;
        rexc_r <= `EXC_NONE;
      end
      else
      begin
        rdy_r  <= (st_nxt == mod_pt_pkg::ST_IDLE) && is_pt(role[p]);
        wrdy_r <= (st_nxt == mod_pt_pkg::ST_DATA) || (st_nxt == mod_pt_pkg::ST_DROP);
        rts_r  <= (st_nxt == mod_pt_pkg::ST_REPLY) && clear_to_send_handshake_on[p];
        rsp_r  <= (st_r == mod_pt_pkg::ST_REPLY) && (st_nxt == mod_pt_pkg::ST_IDLE) && !flush;
        if ((st_r == mod_pt_pkg::ST_REPLY) && (st_nxt == mod_pt_pkg::ST_IDLE))
          rexc_r <= exc_r;
      end
    end

    assign req_ready[p] = rdy_r;
    assign wr_ready[p]  = wrdy_r;
    assign rts[p]       = rts_r;
    assign rsp_valid[p] = rsp_r;
    assign rsp_exc[p]   = rexc_r;
  end
endmodule

//--- modbus_slave_pass_thru_props.sv
// Checker for the pass-thru interpreter top: boot pulses, replies, queue head
// Assumes it sees only top-level ports; bound into every instance below
`timescale 1ns/1ns
`include "mod_pt_params.svh"
module modbus_slave_pass_thru_props (
  // Watched ports
  input wire logic            clk,
  input wire logic            resetn,
  input wire logic [15:0]     blk_seq,
  input wire logic [15:0]     blk_id,
  input wire logic [15:0]     blk_rsp_seq,
  input wire logic            warm_boot,
  input wire logic            cold_boot,
  input wire logic [1:0][2:0] role,
  input wire logic [1:0]      clear_to_send_handshake_on,
  input wire logic [1:0]      req_valid,
  input wire logic [1:0]      req_ready,
  input wire logic [1:0]      rsp_valid,
  input wire logic [1:0]      rts,
  input wire logic [1:0]      cts,
  input wire logic            bp_valid,
  input wire logic            bp_ready,
  input wire logic [15:0]     bp_data
);
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  // ----------------------------------------------------------------
  // Boot blocks and sequence echo
  // ----------------------------------------------------------------
  AST_WARM: assert property ($changed(blk_seq) && blk_id == `WARM_BOOT_ID
    |-> ##[1:2] warm_boot) else $error("warm boot pulse missing");
  AST_COLD: assert property ($changed(blk_seq) && blk_id == `COLD_BOOT_ID
    |-> ##[1:2] cold_boot) else $error("cold boot pulse missing");
  AST_SEQ: assert property ((blk_seq != 16'h0 && $stable(blk_seq)) [*3]
    |-> blk_rsp_seq == blk_seq + 16'h1) else $error("sequence echo wrong");
  // Flush must not leave a stale head for the processor
  AST_FLUSH: assert property (warm_boot |=> !bp_valid)
    else $error("queue not flushed on warm boot");
  // ----------------------------------------------------------------
  // Ports and queue head
  // ----------------------------------------------------------------
  AST_HOLD: assert property (bp_valid && !bp_ready && !warm_boot && !cold_boot
    |=> bp_valid && $stable(bp_data)) else $error("queue head dropped");
  AST_HS: assert property (rsp_valid[0] && clear_to_send_handshake_on[0]
    |-> $past(cts[0], 3) && $past(rts[0])) else $error("reply before clear to send");
  AST_ROLE: assert property (role[0] < 3'h2 && $past(role[0]) < 3'h2
    |-> !req_ready[0]) else $error("request accepted in master or slave role");
  AST_REPLY: assert property (req_valid[0] && req_ready[0] &&
    !clear_to_send_handshake_on[0] |-> ##[4:300] rsp_valid[0]) else $error("no reply");
  COV_WARM: cover property (warm_boot);
  COV_HS: cover property (rsp_valid[0] && clear_to_send_handshake_on[0]);
  COV_STALL: cover property (bp_valid && !bp_ready ##1 bp_valid && bp_ready);
endmodule

bind modbus_slave_pass_thru modbus_slave_pass_thru_props props (.clk, .resetn, .blk_seq,
  .blk_id, .blk_rsp_seq, .warm_boot, .cold_boot, .role, .clear_to_send_handshake_on,
  .req_valid, .req_ready, .rsp_valid, .rts, .cts, .bp_valid, .bp_ready, .bp_data);

//--- proc_model.sv
// Processor side model: drains the queue and issues control blocks
// Assumes the bench calls send_block only between falling edges
`timescale 1ns/1ns
module proc_model (
  // Clock, reset and stall request
  input  wire logic        clk,
  input  wire logic        resetn,
  input  wire logic        stall,
  // Queue drain and control block words
  output logic             bp_ready,
  output logic      [15:0] blk_seq,
  output logic      [15:0] blk_id
);
  integer seed = 50;
  initial
  begin
    bp_ready = 0;
    blk_seq = 16'h0;
    blk_id = 16'h0;
  end
  // Random take rate, so the queue head must hold through stalls
  always @(negedge clk)
    bp_ready = resetn && !stall && ($random(seed) % 3 != 0);
  // A block counts as new only through a fresh sequence number
  task send_block(input logic [15:0] id);
    @(negedge clk);
    blk_id = id;
    blk_seq = blk_seq + 16'h1;
  endtask
endmodule

//--- modbus_slave_pass_thru_bench.sv
// Bench for the pass-thru interpreter: boots, direct and block writes, errors
// Assumes proc_model drains the queue; HOLD_WORDS is cut to 600 words
`timescale 1ns/1ns
`include "mod_pt_params.svh"
module modbus_slave_pass_thru_bench;
  logic                  clk, resetn, stall, bp_valid, bp_first, bp_ready, warm_boot, cold_boot;
  logic [15:0]           blk_seq, blk_id, blk_rsp_seq, blk_rsp_id, bp_blk_id, bp_data;
  logic [19:0]           bp_addr;
  logic [1:0][2:0]       role;
  logic [1:0][7:0]       req_func, rsp_exc;
  logic [1:0][15:0]      req_addr, req_count, wr_data;
  logic [1:0]            req_valid, req_ready, wr_valid, wr_last, wr_ready, rsp_valid, rts, cts;
  logic [1:0]            clear_to_send_handshake_on;
  integer                miscompares = 0;
  integer                total_checks = 0;
  integer                seed = 50;
  mod_pt_pkg::bp_entry_s exp_bp[$];
  logic [7:0]            exp_rsp[2][$];

  modbus_slave_pass_thru #(.QUEUE_DEPTH(128), .HOLD_WORDS(16'h0258)) DUT (.clk, .resetn,
    .blk_seq, .blk_id, .blk_rsp_seq, .blk_rsp_id, .warm_boot, .cold_boot, .role,
    .clear_to_send_handshake_on, .req_valid, .req_func, .req_addr, .req_count, .req_ready,
    .wr_valid, .wr_data, .wr_last, .wr_ready, .rsp_valid, .rsp_exc, .rts, .cts, .bp_valid,
    .bp_first, .bp_blk_id, .bp_addr, .bp_data, .bp_ready);
  proc_model pm (.clk, .resetn, .stall, .bp_ready, .blk_seq, .blk_id);

  initial
  begin
    clk = 0;
    forever #50 clk = ~clk;
  end

  task automatic check(input string what, input logic [52:0] seen, exp);
    total_checks++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task final_report;
    if (miscompares == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Every wait is bounded; running out counts as a mismatch
  task automatic limit(input int t);
    if (t > 600)
    begin
      miscompares++;
      final_report;
    end
  endtask

  task automatic boot(input logic [15:0] id, input logic [1:0] exp);
    logic [1:0] s;
    s = 0;
    pm.send_block(id);
    repeat (3)
    begin
      @(negedge clk);
      s = s | {warm_boot, cold_boot};
    end
    check("boot", s, exp);
    check("seq", {blk_rsp_id, blk_rsp_seq}, {id, pm.blk_seq + 16'h1});
  endtask

  // One master request; data is held until the port takes it
  task automatic send(input int p, input logic [7:0] fc, input logic [15:0] a, c,
                      input int n, input logic [7:0] exc, input logic [15:0] blk);
    logic [15:0] d;
    logic [19:0] ad;
    int          i;
    int          t;
    logic        acc;
    i = 0;
    for (t = 0; req_ready[p] !== 1'b1; t++)
    begin
      limit(t);
      @(negedge clk);
    end
    req_valid[p] = 1;
    req_func[p] = fc;
    req_addr[p] = a;
    req_count[p] = c;
    exp_rsp[p].push_back(exc);
    @(negedge clk);
    req_valid[p] = 0;
    d = 16'($random(seed));
    for (t = 0; i < n; t++)
    begin
      limit(t);
      wr_valid[p] = 1;
      wr_data[p] = d;
      wr_last[p] = (i == n - 1);
      // Ready is settled here and stands for the coming rising edge
      acc = wr_ready[p];
      @(negedge clk);
      ad = (role[p] == 3'h2 ? 20'h0 : `HOLD_BASE) + 20'(a) + 20'(i);
      if (acc)
      begin
        if (exc == 0)
          exp_bp.push_back({i == 0, blk, ad, role[p] == 3'h5 ? {d[7:0], d[15:8]} : d});
        i++;
        d = 16'($random(seed));
      end
    end
    wr_valid[p] = 0;
    wr_last[p] = 0;
  endtask

  // Match each drained word and each reply against the oldest note
  always @(posedge clk)
  begin
    if (bp_valid && bp_ready)
      check("bp", {bp_first, bp_blk_id, bp_addr, bp_data}, exp_bp.pop_front());
    for (int p = 0; p < 2; p++)
      if (rsp_valid[p])
        check("reply", rsp_exc[p], exp_rsp[p].pop_front());
  end

  initial
  begin
    {resetn, stall, req_valid, wr_valid, wr_last, cts, clear_to_send_handshake_on} = '0;
    {req_func, req_addr, req_count, wr_data} = '0;
    role = {3'h5, 3'h4};
    repeat (3) @(negedge clk);
    resetn = 1;
    boot(16'h1234, 2'b00);
    boot(`WARM_BOOT_ID, 2'b10);
    boot(`COLD_BOOT_ID, 2'b01);
    for (int r = 0; r < 2; r++)
    begin
      role[0] = 3'(r);
      repeat (3) @(negedge clk);
      check("idle role", req_ready[0], 0);
    end
    role[0] = 3'h4;
    send(0, `FC_WR_REG, 500, 1, 1, 0, 0);
    fork
      send(0, `FC_WR_REGS, 100, 3, 3, 0, 0);
      send(1, `FC_WR_REGS, 200, 125, 125, 0, 0);
    join
    send(0, 8'h03, 0, 1, 1, `EXC_ILL_FUNC, 0);
    send(0, `FC_WR_COILS, 0, 16, 1, `EXC_ILL_FUNC, 0);
    send(0, `FC_WR_REGS, 0, 126, 126, `EXC_ILL_VALUE, 0);
    send(0, `FC_WR_REGS, 599, 2, 2, `EXC_ILL_ADDR, 0);
    send(0, `FC_WR_REG, 599, 1, 1, 0, 0);
    stall = 1;
    send(0, `FC_WR_REGS, 10, 8, 8, 0, 0);
    send(0, `FC_WR_REGS, 20, 125, 125, `EXC_BUSY, 0);
    stall = 0;
    role[0] = 3'h2;
    send(0, `FC_WR_COIL, 7, 1, 1, 0, `BLK_ID_COIL);
    send(0, `FC_WR_REG, 8, 1, 1, 0, `BLK_ID_REG);
    send(0, `FC_WR_COILS, 9, 800, 50, 0, `BLK_ID_COILS);
    send(0, `FC_WR_COILS, 9, 801, 51, `EXC_ILL_VALUE, 0);
    send(0, `FC_WR_REGS, 64, 2, 2, 0, `BLK_ID_REGS);
    // Let the last block reply leave before the handshake gates replies
    repeat (4) @(negedge clk);
    role[0] = 3'h4;
    clear_to_send_handshake_on[0] = 1;
    fork
      send(0, `FC_WR_REG, 30, 1, 1, 0, 0);
      begin
        repeat (12) @(negedge clk);
        check("rts", rts[0], 1);
        check("held", exp_rsp[0].size(), 1);
        cts[0] = 1;
      end
    join
    // Warm boot with words still queued: the queue must come back empty
    stall = 1;
    send(0, `FC_WR_REGS, 40, 2, 2, 0, 0);
    boot(`WARM_BOOT_ID, 2'b10);
    check("flushed", bp_valid, 0);
    exp_bp.delete();
    stall = 0;
    repeat (300) @(negedge clk);
    check("left", exp_bp.size() + exp_rsp[0].size() + exp_rsp[1].size(), 0);
    final_report;
  end
endmodule
